// File: rtl/arm_pkg.sv
// Package of constants for the converter repeat-mode control block.
// Assumes a Wishbone slave with byte-wide control registers and 10-bit result registers in the low data bits.
package arm_pkg;

    // Register offsets are word indexes; the byte address on the bus is four times the index.
    localparam logic [9:0] CTRL0_IDX     = 10'h3D6;
    localparam logic [9:0] CTRL1_IDX     = 10'h3D7;
    localparam logic [9:0] CTRL2_IDX     = 10'h3D8;
    localparam logic [9:0] STATUS_IDX    = 10'h3D9;
    localparam logic [9:0] RESULT0_IDX   = 10'h3C0;
    localparam logic [11:0] CTRL0_ADDR   = {CTRL0_IDX, 2'h0};
    localparam logic [11:0] CTRL1_ADDR   = {CTRL1_IDX, 2'h0};
    localparam logic [11:0] CTRL2_ADDR   = {CTRL2_IDX, 2'h0};
    localparam logic [11:0] STATUS_ADDR  = {STATUS_IDX, 2'h0};
    localparam logic [11:0] RESULT0_ADDR = {RESULT0_IDX, 2'h0};

    // Control register 0 fields.
    localparam int CH_LSB   = 0;
    localparam int MODE_BIT = 3;
    localparam int TRG_BIT  = 5;
    localparam int START_BIT = 6;
    localparam int DIVA_BIT = 7;
    // Control register 1 fields.
    localparam int RES_BIT  = 3;
    localparam int DIVB_BIT = 4;
    localparam int VREF_BIT = 5;
    localparam int OPA_LSB  = 6;
    // Control register 2 fields.
    localparam int GSEL_LSB = 1;
    localparam int DIVC_BIT = 4;

    // Values after reset.
    localparam logic [7:0] CTRL0_RST = 8'h00;
    localparam logic [7:0] CTRL1_RST = 8'h00;
    localparam logic [7:0] CTRL2_RST = 8'h00;
    // Writable bit masks; unassigned bits hold zero.
    localparam logic [7:0] CTRL0_MASK = 8'hEF;
    localparam logic [7:0] CTRL1_MASK = 8'hF8;
    localparam logic [7:0] CTRL2_MASK = 8'h16;

    // External op-amp field codes.
    localparam logic [1:0] OPA_NONE = 2'h0;
    localparam logic [1:0] OPA_EX0  = 2'h1;
    localparam logic [1:0] OPA_EX1  = 2'h2;

    // Conversion timing in converter clock cycles.
    localparam logic [5:0] CONV_CYC_8  = 6'h1C;
    localparam logic [5:0] CONV_CYC_10 = 6'h21;
    localparam int NUM_INPUTS = 8;

    // Conversion sequencer states, Gray coded along idle, arm, convert.
    typedef enum logic [1:0] {
        ARM_IDLE = 2'b00,
        ARM_WAIT = 2'b01,
        ARM_CONV = 2'b11
    } arm_state_e;

endpackage : arm_pkg

// File: rtl/arm_clkdiv.sv
// Converter clock divider producing a one-cycle tick.
// Assumes a synchronised active-low reset from the top module.
`timescale 1ns/10ps
module arm_clkdiv (
    input  wire logic       clock_i,   // System clock.
    input  wire logic       rst_b_i,   // Synchronised reset, active low.
    input  wire logic [2:0] div_sel_i, // Divider code.
    output logic            tick_o     // Converter clock tick.
);

    logic [6:0] cnt_q;
    logic [6:0] limit;

    // Divider code selects division by 1, 2, 4 ... 128.
    always_comb
    begin
        limit = 7'((8'h01 << div_sel_i) - 8'h01);
    end

    // Free-running count producing one tick per period.
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cnt_q  <= 7'h00;
            tick_o <= 1'b0;
        end
        else if (cnt_q >= limit)
        begin
            cnt_q  <= 7'h00;
            tick_o <= 1'b1;
        end
        else
        begin
            cnt_q  <= cnt_q + 7'h01;
            tick_o <= 1'b0;
        end
    end

endmodule : arm_clkdiv

// File: rtl/arm_top.sv
// What this block does
// - Repeat conversions while start flag set.
// - Input from channel, group, op-amp fields.
// - Channel field maps to inputs 0..7.
// - Mode bit one selects repeat mode.
// - Software trigger starts on flag write.
// - External trigger starts on later falling edge.
// - Clearing start flag halts conversion.
// - Result lands in the input's register.
// - Unassigned bits write zero, read undefined.
// - Resolution bit picks eight or ten bits.
// - Op-amp field selects extended inputs.
// - Alternate group behaves like primary group.
// - Three divider bits set converter clock.
// - Block reference and start hazards.
// - Extended inputs store in results 0, 1.
//
// Converter control top with Wishbone register slave.
// Assumes an analog core that samples sample_input_o and returns a 10-bit code on conv_data_i.
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/10ps
module arm_top (
    input  wire logic        clock_i,        // 100 MHz system clock.
    input  wire logic        rst_b_i,        // Asynchronous reset, active low.
    input  wire logic        wb_cyc_i,       // Wishbone cycle.
    input  wire logic        wb_stb_i,       // Wishbone strobe.
    input  wire logic        wb_we_i,        // Wishbone write enable.
    input  wire logic [11:0] wb_adr_i,       // Wishbone byte address.
    input  wire logic [3:0]  wb_sel_i,       // Wishbone byte selects.
    input  wire logic [31:0] wb_dat_i,       // Wishbone write data.
    output logic [31:0]      wb_dat_o,       // Wishbone read data.
    output logic             wb_ack_o,       // Wishbone acknowledge.
    input  wire logic        external_trigger_pin_i, // Trigger pin, falling edge starts.
    input  wire logic [9:0]  conv_data_i,    // Code from analog core.
    output logic [4:0]       sample_input_o, // Selected analog input code.
    output logic             vref_on_o,      // Reference ladder connected.
    output logic             converting_o    // Conversion running.
);

    logic       rst_meta_q;
    logic       rst_sync_q;
    logic [7:0] ctrl0_q;
    logic [7:0] ctrl1_q;
    logic [7:0] ctrl2_q;
    logic [9:0] result_q [arm_pkg::NUM_INPUTS];
    logic       trig_q;
    logic       div_tick;
    logic [5:0] cyc_q;
    logic [2:0] dest;
    logic [4:0] sel_code;
    logic       wr_acc;
    logic       rd_acc;
    logic       running;
    logic       conv_done;
    logic [7:0] wr_byte;
    logic [7:0] rd_byte;
    logic [31:0] rd_word;
    arm_pkg::arm_state_e state_q;

    // Release reset through two flip-flops.
    always_ff @(posedge clock_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end
        else
        begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    // Bus decode; every access is answered one cycle after it is taken.
    // A write lands on the edge at which the master sees the acknowledge, never earlier.
    assign wr_acc  = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && wb_ack_o;
    assign rd_acc  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_byte = wb_dat_i[7:0];
    assign running = (state_q == arm_pkg::ARM_CONV);

    // Divider bits from three registers.
    // divider bit combination
    arm_clkdiv u_div (
        .clock_i   (clock_i),
        .rst_b_i   (rst_sync_q),
        .div_sel_i ({ctrl2_q[arm_pkg::DIVC_BIT], ctrl1_q[arm_pkg::DIVB_BIT], ctrl0_q[arm_pkg::DIVA_BIT]}),
        .tick_o    (div_tick)
    );

    // Control register 0 with start flag handling.
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ctrl0_q <= arm_pkg::CTRL0_RST;
        end
        else if (wr_acc && wb_adr_i == arm_pkg::CTRL0_ADDR)
        begin
            ctrl0_q <= wr_byte & arm_pkg::CTRL0_MASK;
            if (!ctrl1_q[arm_pkg::VREF_BIT])
            begin
                ctrl0_q[arm_pkg::START_BIT] <= 1'b0;
            end
        end
    end

    // Control register 1; reference may not drop while converting.
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ctrl1_q <= arm_pkg::CTRL1_RST;
        end
        else if (wr_acc && wb_adr_i == arm_pkg::CTRL1_ADDR)
        begin
            ctrl1_q <= wr_byte & arm_pkg::CTRL1_MASK;
            if (ctrl0_q[arm_pkg::START_BIT])
            begin
                ctrl1_q[arm_pkg::VREF_BIT] <= 1'b1;
            end
        end
    end

    // Control register 2 holds group select and third divider bit.
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            ctrl2_q <= arm_pkg::CTRL2_RST;
        end
        else if (wr_acc && wb_adr_i == arm_pkg::CTRL2_ADDR)
        begin
            ctrl2_q <= wr_byte & arm_pkg::CTRL2_MASK;
        end
    end

    // Input selection and result destination.
    // combined input select
    always_comb
    begin
        dest     = ctrl0_q[arm_pkg::CH_LSB +: 3];
        sel_code = {1'b0, ctrl2_q[arm_pkg::GSEL_LSB], dest};
        unique case (ctrl1_q[arm_pkg::OPA_LSB +: 2])
            arm_pkg::OPA_EX0:
            begin
                dest     = 3'h0;
                sel_code = 5'h10;
            end
            arm_pkg::OPA_EX1:
            begin
                dest     = 3'h1;
                sel_code = 5'h11;
            end
            default:
            begin
            end
        endcase
    end

    // Trigger pin history for falling edge detection.
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            trig_q <= 1'b1;
        end
        else
        begin
            trig_q <= external_trigger_pin_i;
        end
    end

    // Sequencer: idle, waiting for trigger, converting repeatedly.
    // no interrupt output exists
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            state_q <= arm_pkg::ARM_IDLE;
        end
        else
        begin
            unique case (state_q)
                arm_pkg::ARM_IDLE:
                begin
                    if (ctrl0_q[arm_pkg::START_BIT] && ctrl0_q[arm_pkg::MODE_BIT])
                    begin
                        state_q <= ctrl0_q[arm_pkg::TRG_BIT] ? arm_pkg::ARM_WAIT : arm_pkg::ARM_CONV;
                    end
                end
                arm_pkg::ARM_WAIT:
                begin
                    if (!ctrl0_q[arm_pkg::START_BIT])
                    begin
                        state_q <= arm_pkg::ARM_IDLE;
                    end
                    else if (trig_q && !external_trigger_pin_i)
                    begin
                        state_q <= arm_pkg::ARM_CONV;
                    end
                end
                arm_pkg::ARM_CONV:
                begin
                    if (!ctrl0_q[arm_pkg::START_BIT])
                    begin
                        state_q <= arm_pkg::ARM_IDLE;
                    end
                end
                default:
                begin
                    state_q <= arm_pkg::ARM_IDLE;
                end
            endcase
        end
    end

    // Conversion cycle counter; restarts after each completion.
    // continuous reconversion
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            cyc_q <= 6'h00;
        end
        else if (!running)
        begin
            cyc_q <= 6'h00;
        end
        else if (div_tick)
        begin
            cyc_q <= conv_done ? 6'h00 : cyc_q + 6'h01;
        end
    end

    assign conv_done = div_tick && running && (cyc_q == ((ctrl1_q[arm_pkg::RES_BIT] ?
                       arm_pkg::CONV_CYC_10 : arm_pkg::CONV_CYC_8) - 6'h01));

    // Result store to the selected input's register.
    // result to own register
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            for (int i = 0; i < arm_pkg::NUM_INPUTS; i++)
            begin
                result_q[i] <= 10'h000;
            end
        end
        else if (conv_done)
        begin
            result_q[dest] <= ctrl1_q[arm_pkg::RES_BIT] ? conv_data_i : {2'h0, conv_data_i[9:2]};
        end
    end

    // Read multiplexer; the word is registered together with the acknowledge.
    always_comb
    begin
        rd_byte = 8'h00;
        rd_word = 32'h0000_0000;
        unique case (wb_adr_i)
            arm_pkg::CTRL0_ADDR:  rd_byte = ctrl0_q;
            arm_pkg::CTRL1_ADDR:  rd_byte = ctrl1_q;
            arm_pkg::CTRL2_ADDR:  rd_byte = ctrl2_q;
            arm_pkg::STATUS_ADDR: rd_byte = {6'h00, state_q};
            default:              rd_byte = 8'h00;
        endcase
        if (wb_adr_i[11:5] == arm_pkg::RESULT0_ADDR[11:5])
        begin
            rd_word = {22'h000000, result_q[wb_adr_i[4:2]]};
        end
        else
        begin
            rd_word = {24'h000000, rd_byte};
        end
    end

    // Acknowledge and status outputs.
    always_ff @(posedge clock_i or negedge rst_sync_q)
    begin
        if (!rst_sync_q)
        begin
            wb_ack_o       <= 1'b0;
            wb_dat_o       <= 32'h0000_0000;
            sample_input_o <= 5'h00;
            vref_on_o      <= 1'b0;
            converting_o   <= 1'b0;
        end
        else
        begin
            wb_ack_o       <= rd_acc;
            wb_dat_o       <= rd_acc ? rd_word : 32'h0000_0000;
            sample_input_o <= sel_code;
            vref_on_o      <= ctrl1_q[arm_pkg::VREF_BIT];
            converting_o   <= running;
        end
    end

    a_start_vref: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        ctrl0_q[arm_pkg::START_BIT] |-> ctrl1_q[arm_pkg::VREF_BIT])
        else $error("Start flag set without reference.");
    a_stop_flag: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        !ctrl0_q[arm_pkg::START_BIT] |=> state_q == arm_pkg::ARM_IDLE)
        else $error("Conversion continued after clear.");
    a_trig_edge: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        state_q == arm_pkg::ARM_WAIT && ctrl0_q[arm_pkg::START_BIT] && trig_q && !external_trigger_pin_i
        |=> state_q == arm_pkg::ARM_CONV)
        else $error("Trigger edge missed.");
    a_soft_start: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        state_q == arm_pkg::ARM_IDLE && ctrl0_q[arm_pkg::START_BIT] && ctrl0_q[arm_pkg::MODE_BIT]
        && !ctrl0_q[arm_pkg::TRG_BIT] |=> state_q == arm_pkg::ARM_CONV)
        else $error("Software start missed.");
    a_ext_sel: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        ctrl1_q[arm_pkg::OPA_LSB +: 2] == arm_pkg::OPA_EX1 |=> sample_input_o == 5'h11)
        else $error("Extended input one not selected.");
    a_ext_dest: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        conv_done && ctrl1_q[arm_pkg::OPA_LSB +: 2] == arm_pkg::OPA_EX0 && ctrl1_q[arm_pkg::RES_BIT]
        |=> result_q[0] == $past(conv_data_i))
        else $error("Extended result misplaced.");
    a_chan_map: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        ctrl1_q[arm_pkg::OPA_LSB +: 2] == arm_pkg::OPA_NONE
        |=> sample_input_o[2:0] == $past(ctrl0_q[2:0]))
        else $error("Channel mapping wrong.");
    a_repeat_run: assert property (@(posedge clock_i) disable iff (!rst_sync_q)
        conv_done && ctrl0_q[arm_pkg::START_BIT] |=> running && cyc_q == 6'h00)
        else $error("Repeat did not restart.");

endmodule : arm_top

// File: verif/arm_analog_model.sv
// Behavioural analog core that answers the block with a conversion code.
// Assumes the bench sets the analog level before a conversion ends.
`timescale 1ns/10ps
module arm_analog_model (
    input  wire logic [4:0] sample_input_i, // Selected input code.
    input  wire logic [9:0] level_i,        // Analog level from the bench.
    output logic      [9:0] conv_data_o     // Code returned to the block.
);
    // input dependent code
    // Each input folds its own code into the level, so a result stored in the wrong place shows up.
    assign conv_data_o = level_i ^ {sample_input_i, 5'h00};
endmodule : arm_analog_model

// File: verif/tb_adc_repeat_mode_control.sv
// Self-checking bench for the repeat-mode converter control block.
// Assumes the analog model in its own file and a one-cycle Wishbone answer.
`timescale 1ns/10ps
module tb_adc_repeat_mode_control;
    logic        clock_i   = 1'b0;
    logic        rst_b_i   = 1'b0;
    logic        cyc       = 1'b0;
    logic        stb       = 1'b0;
    logic        we        = 1'b0;
    logic [11:0] adr       = 12'h000;
    logic [31:0] dat       = 32'h00000000;
    logic        pin       = 1'b1;
    logic [9:0]  lvl       = 10'h000;
    logic [31:0] rd;
    logic        ack;
    logic [9:0]  cdat;
    logic [4:0]  sel_o;
    logic        vref;
    logic        conv;
    logic [31:0] q;
    int          error_cnt = 0;
    int          n_tests   = 0;
    integer      seed      = 32'h9D7C;

    // Free-running system clock.
    always #5 clock_i = ~clock_i;

    arm_top u_dut (
        .clock_i              (clock_i),
        .rst_b_i              (rst_b_i),
        .wb_cyc_i             (cyc),
        .wb_stb_i             (stb),
        .wb_we_i              (we),
        .wb_adr_i             (adr),
        .wb_sel_i             (4'h1),
        .wb_dat_i             (dat),
        .wb_dat_o             (rd),
        .wb_ack_o             (ack),
        .external_trigger_pin_i (pin),
        .conv_data_i          (cdat),
        .sample_input_o       (sel_o),
        .vref_on_o            (vref),
        .converting_o         (conv)
    );

    arm_analog_model u_core (
        .sample_input_i (sel_o),
        .level_i        (lvl),
        .conv_data_o    (cdat)
    );

    // Counts a comparison and reports a mismatch.
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    // One classic Wishbone cycle; read data lands in q.
    task automatic wb(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        @(posedge clock_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= a;
        dat <= {24'h000000, d};
        n = 0;
        do
        begin
            @(posedge clock_i);
            n++;
        end
        while (ack !== 1'b1 && n < 50);
        if (n >= 50)
            error_cnt++;
        q = rd;
        cyc <= 1'b0;
        stb <= 1'b0;
        we  <= 1'b0;
    endtask : wb

    // Prints the verdict and ends the run.
    task automatic report_and_stop();
        if (error_cnt == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : report_and_stop

    // Sets up one input, starts the repeat, checks two results and halts it.
    task automatic run(input int ch, input int grp, input int opa, input int b10, input int trigger_source_bit);
        int s;
        int e;
        s = (opa != 0) ? 15 + opa : ch + 8 * grp;
        // set up while the converter is idle
        wb(1'b1, arm_pkg::CTRL2_ADDR, 8'(grp << 1));
        wb(1'b1, arm_pkg::CTRL1_ADDR, 8'(32 | opa << 6 | b10 << 3));
        wb(1'b1, arm_pkg::CTRL0_ADDR, 8'h08);
        wb(1'b1, arm_pkg::CTRL0_ADDR, 8'(8 | ch | trigger_source_bit << 5));
        repeat (120) @(posedge clock_i);
        wb(1'b1, arm_pkg::CTRL0_ADDR, 8'(72 | ch | trigger_source_bit << 5));
        if (trigger_source_bit != 0)
        begin
            repeat (40) @(posedge clock_i);
            chk("wait_trigger", 32'(conv), 32'h0);
            wb(1'b0, arm_pkg::STATUS_ADDR, 8'h00);
            chk("status_wait", q, 32'h1);
            pin <= 1'b0;
            repeat (3) @(posedge clock_i);
            pin <= 1'b1;
        end
        repeat (2)
        begin
            lvl <= 10'($random(seed));
            repeat (80) @(posedge clock_i);
            e = int'(lvl ^ 10'(s << 5));
            if (b10 == 0)
                e = e >> 2;
            chk("converting", 32'(conv), 32'h1);
            chk("sample_input", 32'(sel_o), 32'(s));
            wb(1'b0, arm_pkg::STATUS_ADDR, 8'h00);
            chk("status_conv", q, 32'h3);
            wb(1'b0, 12'(arm_pkg::RESULT0_ADDR + 4 * ((opa != 0) ? opa - 1 : ch)), 8'h00);
            chk("result", q, 32'(e));
        end
        wb(1'b1, arm_pkg::CTRL1_ADDR, 8'(opa << 6 | b10 << 3));
        repeat (2) @(posedge clock_i);
        chk("vref_held", 32'(vref), 32'h1);
        wb(1'b1, arm_pkg::CTRL0_ADDR, 8'(8 | ch | trigger_source_bit << 5));
        repeat (3) @(posedge clock_i);
        chk("halted", 32'(conv), 32'h0);
    endtask : run

    // Main sequence: reset, register checks, then every channel, group, op-amp code and trigger.
    initial
    begin
        repeat (16) @(posedge clock_i);
        rst_b_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        chk("reset_conv", 32'(conv), 32'h0);
        chk("reset_vref", 32'(vref), 32'h0);
        chk("reset_sel", 32'(sel_o), 32'h0);
        for (int c = 0; c < 3; c++)
        begin
            wb(1'b0, 12'(arm_pkg::CTRL0_ADDR + 4 * c), 8'h00);
            chk("reset_value", q, 32'h0);
        end
        wb(1'b1, arm_pkg::CTRL0_ADDR, 8'hEF);
        wb(1'b0, arm_pkg::CTRL0_ADDR, 8'h00);
        chk("ctrl0_bits", q, 32'h000000AF);
        chk("no_start", 32'(conv), 32'h0);
        wb(1'b1, arm_pkg::CTRL0_ADDR, 8'h00);
        wb(1'b1, arm_pkg::CTRL1_ADDR, 8'h38);
        wb(1'b0, arm_pkg::CTRL1_ADDR, 8'h00);
        chk("ctrl1_bits", q, 32'h00000038);
        chk("vref_on", 32'(vref), 32'h1);
        wb(1'b1, 12'hFFC, 8'h5A);
        wb(1'b0, 12'hFFC, 8'h00);
        chk("unmapped", q, 32'h0);
        for (int c = 0; c < 8; c++)
            run(c, 0, 0, 1, 0);
        run(int'($random(seed)) & 7, 1, 0, 0, 1);
        run(3, 0, 1, 1, 0);
        run(5, 0, 2, 0, 1);
        report_and_stop();
    end

    // Watchdog well beyond the expected run length.
    initial
    begin
        repeat (20000) @(posedge clock_i);
        error_cnt++;
        report_and_stop();
    end
endmodule : tb_adc_repeat_mode_control
